// ---- rtl/clock_gen_control_regs.sv ----
// Control registers and clock source steering of the clock generation unit
`timescale 1ns/1ps
`default_nettype none

module clock_gen_control_regs
  import clock_gen_pkg::*;
#(
  parameter int EXT_COUNT = EXT_STARTUP_CYCLES,
  parameter logic [7:0] TRIM_5V_VALUE = 8'h80,
  parameter logic [7:0] TRIM_3V_VALUE = 8'h80
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Configuration and mode
  input wire logic ext_clock_option,
  input wire logic stop_osc_option,
  input wire logic stop_mode,
  // Oscillator status
  input wire logic internal_lock,
  input wire logic internal_inactive,
  input wire logic external_inactive,
  input wire logic external_clock_edge,
  // Loop filter values for divider and stage
  input wire logic [3:0] filter_divider,
  input wire logic [7:0] filter_stage,
  // Outputs to the oscillator and interrupt logic
  output logic monitor_irq,
  output logic internal_osc_enable,
  output logic external_osc_enable,
  output logic osc_select_external,
  output logic clocks_running,
  output logic [6:0] effective_multiplier,
  output logic [3:0] effective_divider,
  output logic [6:0] clock_multiplier,
  output logic [7:0] clock_trim,
  output logic [3:0] divider_field,
  output logic [7:0] stage_field
);

  function automatic logic [3:0] clamp_div(input logic [3:0] v);
    clamp_div = (v > DIV_MAX) ? DIV_MAX : v;
  endfunction

  // A stored zero multiplier drives the oscillator as a one
  function automatic logic [6:0] map_mult(input logic [6:0] v);
    map_mult = (v == MULT_ZERO) ? MULT_ONE : v;
  endfunction

  // Strobe aimed at one register index
  function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] idx);
    hit = strobe && (a == idx);
  endfunction

  // Counter width follows the startup count, so a shorter count costs fewer flops
  localparam int CNT_W = $clog2(EXT_COUNT) + 1;

  ////////////////////////////////////////////////////////////////////////
  // Control bits

  logic monitor_irq_enable;
  logic monitor_flag;
  logic monitor_on;
  logic clock_sel;
  logic internal_on;
  logic internal_stable;
  logic external_on;
  logic external_stable;
  logic flag_read_armed;
  logic [CNT_W-1:0] ext_count;
  // Copies one bus cycle old
  logic prev_mon_on;
  logic prev_sel;
  logic prev_int_on;
  logic prev_int_st;
  logic prev_ext_on;
  logic prev_ext_st;
  logic next_irq_en;
  logic next_flag;
  logic next_mon_on;
  logic next_sel;
  logic next_int_on;
  logic next_int_st;
  logic next_ext_on;
  logic next_ext_st;
  logic next_armed;
  logic [CNT_W-1:0] next_ext_count;
  logic [6:0] next_mult;
  logic [7:0] next_trim, next_stage, next_rdata;
  logic [3:0] next_div;
  logic wr_ctl;
  logic wr_mult_ok;
  logic wr_trim_ok;
  logic halt;
  logic int_lost;
  logic ext_lost;

  assign wr_ctl = hit(wr, addr, ADDR_CONTROL);
  assign wr_mult_ok = hit(wr, addr, ADDR_MULT) && !monitor_on;
  assign wr_trim_ok = hit(wr, addr, ADDR_TRIM) && !monitor_on;
  assign halt = stop_mode && !stop_osc_option;
  assign int_lost = monitor_on && internal_inactive;
  assign ext_lost = monitor_on && external_inactive;

  always_comb begin
    next_irq_en = monitor_irq_enable;
    next_flag = monitor_flag;
    next_mon_on = monitor_on;
    next_sel = clock_sel;
    next_int_on = internal_on;
    next_ext_on = external_on;
    next_armed = flag_read_armed;
    next_ext_count = ext_count;
    // Software requests, qualified by last-cycle copies of the bits
    if (wr_ctl) begin
      if (wdata[BIT_IRQ_EN] && prev_mon_on) begin
        next_irq_en = 1'b1;
      end else if (!wdata[BIT_IRQ_EN]) begin
        next_irq_en = 1'b0;
      end
      if (wdata[BIT_MON_ON] && prev_int_on && prev_ext_on && prev_int_st
          && prev_ext_st) begin
        next_mon_on = 1'b1;
      end else if (!wdata[BIT_MON_ON]) begin
        next_mon_on = 1'b0;
      end
      if (wdata[BIT_SEL] && prev_ext_on && prev_ext_st) begin
        next_sel = 1'b1;
      end else if (!wdata[BIT_SEL] && prev_int_on && prev_int_st) begin
        next_sel = 1'b0;
      end
      if (wdata[BIT_INT_ON]) begin
        next_int_on = 1'b1;
      end else if (prev_sel && !prev_mon_on) begin
        next_int_on = 1'b0;
      end
      if (wdata[BIT_EXT_ON] && ext_clock_option) begin
        next_ext_on = 1'b1;
      end else if (!wdata[BIT_EXT_ON] && !prev_sel && !prev_mon_on) begin
        next_ext_on = 1'b0;
      end
      // Clearing needs a prior read that saw the flag set
      if (!wdata[BIT_FLAG] && flag_read_armed) begin
        next_flag = 1'b0;
        next_armed = 1'b0;
      end
    end
    if (hit(rd, addr, ADDR_CONTROL) && monitor_flag) begin
      next_armed = 1'b1;
    end
    // Detection wins over a clear in the same cycle
    if (int_lost || ext_lost) begin
      next_flag = 1'b1;
    end
    // Forcing terms
    if (next_flag) begin
      next_mon_on = 1'b1;
    end
    if (!next_int_on || !next_ext_on || halt) begin
      next_mon_on = 1'b0;
    end
    if (next_mon_on || !next_sel) begin
      next_int_on = 1'b1;
    end
    if (next_mon_on || next_sel) begin
      next_ext_on = 1'b1;
    end
    if (!ext_clock_option) begin
      next_ext_on = 1'b0;
    end
    if (int_lost || !next_int_on) begin
      next_sel = 1'b1;
    end
    if (ext_lost || !next_ext_on) begin
      next_sel = 1'b0;
    end
    if (!next_ext_on || !ext_clock_option) begin
      next_int_on = 1'b1;
      next_mon_on = 1'b0;
    end
    if (!next_mon_on) begin
      next_irq_en = 1'b0;
      next_flag = 1'b0;
      next_armed = 1'b0;
    end
    // Stable indications
    next_int_st = internal_lock;
    if (internal_inactive || !next_int_on || wr_mult_ok || wr_trim_ok || halt) begin
      next_int_st = 1'b0;
    end
    next_ext_st = external_stable;
    if (external_inactive || !next_ext_on || halt) begin
      next_ext_st = 1'b0;
      next_ext_count = '0;
    end else if (!external_stable && external_clock_edge) begin
      // Edges are counted on the bus clock; the external edge arrives pre-synchronised
      if (ext_count == CNT_W'(EXT_COUNT - 1)) begin
        next_ext_st = 1'b1;
      end else begin
        next_ext_count = ext_count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      monitor_irq_enable <= 1'b0;
      monitor_flag <= 1'b0;
      monitor_on <= 1'b0;
      clock_sel <= 1'b0;
      internal_on <= 1'b1;
      internal_stable <= 1'b0;
      external_on <= 1'b0;
      external_stable <= 1'b0;
      flag_read_armed <= 1'b0;
      ext_count <= '0;
    end else if (ce) begin
      monitor_irq_enable <= next_irq_en;
      monitor_flag <= next_flag;
      monitor_on <= next_mon_on;
      clock_sel <= next_sel;
      internal_on <= next_int_on;
      internal_stable <= next_int_st;
      external_on <= next_ext_on;
      external_stable <= next_ext_st;
      flag_read_armed <= next_armed;
      ext_count <= next_ext_count;
    end
  end

  // Registered copies for the one-bus-cycle qualifications
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_mon_on <= 1'b0;
      prev_sel <= 1'b0;
      prev_int_on <= 1'b1;
      prev_int_st <= 1'b0;
      prev_ext_on <= 1'b0;
      prev_ext_st <= 1'b0;
    end else if (ce) begin
      prev_mon_on <= monitor_on;
      prev_sel <= clock_sel;
      prev_int_on <= internal_on;
      prev_int_st <= internal_stable;
      prev_ext_on <= external_on;
      prev_ext_st <= external_stable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frequency settings

  always_comb begin
    next_mult = clock_multiplier;
    next_trim = clock_trim;
    next_div = divider_field;
    next_stage = stage_field;
    if (wr_mult_ok) begin
      next_mult = wdata[6:0];
    end
    if (wr_trim_ok) begin
      next_trim = wdata;
    end
    if (internal_on) begin
      next_div = filter_divider;
      next_stage = filter_stage;
    end else begin
      if (hit(wr, addr, ADDR_DIVIDER)) begin
        next_div = wdata[3:0];
      end
      if (hit(wr, addr, ADDR_STAGE)) begin
        next_stage = wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_multiplier <= MULT_RESET;
      clock_trim <= TRIM_RESET;
    end else if (ce) begin
      clock_multiplier <= next_mult;
      clock_trim <= next_trim;
    end
  end

  // Divider and stage have no reset: the oscillator runs through reset
  always_ff @(posedge clk) begin
    if (ce) begin
      divider_field <= next_div;
      stage_field <= next_stage;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port and outputs

  always_comb begin
    case (addr)
      ADDR_CONTROL: next_rdata = {monitor_irq_enable, monitor_flag, monitor_on, clock_sel,
                                  internal_on, internal_stable, external_on, external_stable};
      ADDR_MULT: next_rdata = {1'b0, clock_multiplier};
      ADDR_TRIM: next_rdata = clock_trim;
      ADDR_DIVIDER: next_rdata = {4'h0, divider_field};
      ADDR_STAGE: next_rdata = stage_field;
      ADDR_TRIM_5V: next_rdata = TRIM_5V_VALUE;
      ADDR_TRIM_3V: next_rdata = TRIM_3V_VALUE;
      default: next_rdata = READ_ZERO;
    endcase
  end

  // Outputs follow the next state, so they change on the same edge as the bits
  logic next_irq;
  logic next_int_en;
  logic next_ext_en;
  logic next_osc_sel;
  logic next_running;
  logic [6:0] next_eff_mult;
  logic [3:0] next_eff_div;
  logic [7:0] next_rdata_out;

  always_comb begin
    next_irq = next_irq_en && next_flag;
    next_int_en = next_int_on && !halt;
    next_ext_en = next_ext_on && !halt;
    next_osc_sel = next_sel;
    next_running = !halt;
    next_eff_mult = map_mult(next_mult);
    next_eff_div = clamp_div(next_div);
    // Read data stands one cycle only, zero between reads
    next_rdata_out = rd ? next_rdata : READ_ZERO;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= READ_ZERO;
      monitor_irq <= 1'b0;
      internal_osc_enable <= 1'b1;
      external_osc_enable <= 1'b0;
      osc_select_external <= 1'b0;
      clocks_running <= 1'b1;
      effective_multiplier <= MULT_RESET;
      effective_divider <= '0;
    end else if (ce) begin
      rdata <= next_rdata_out;
      monitor_irq <= next_irq;
      internal_osc_enable <= next_int_en;
      external_osc_enable <= next_ext_en;
      osc_select_external <= next_osc_sel;
      clocks_running <= next_running;
      effective_multiplier <= next_eff_mult;
      effective_divider <= next_eff_div;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/clock_gen_pkg.sv ----
// Package with register map, field layouts and reset values of the clock generation unit
package clock_gen_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_MULT = 3'h1;
  localparam logic [2:0] ADDR_TRIM = 3'h2;
  localparam logic [2:0] ADDR_DIVIDER = 3'h3;
  localparam logic [2:0] ADDR_STAGE = 3'h4;
  localparam logic [2:0] ADDR_TRIM_5V = 3'h5;
  localparam logic [2:0] ADDR_TRIM_3V = 3'h6;
  // Address printed for the stored factory trim values
  localparam logic [15:0] TRIM_5V_LOCATION = 16'hFF80;
  localparam logic [15:0] TRIM_3V_LOCATION = 16'hFF81;
  // Control register bit positions
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_FLAG = 6;
  localparam int BIT_MON_ON = 5;
  localparam int BIT_SEL = 4;
  localparam int BIT_INT_ON = 3;
  localparam int BIT_INT_STABLE = 2;
  localparam int BIT_EXT_ON = 1;
  localparam int BIT_EXT_STABLE = 0;
  // Reset values, multiplier zero and one mapping, divider limit and idle read value
  localparam logic [6:0] MULT_RESET = 7'h15;
  localparam logic [6:0] MULT_ZERO = 7'h00;
  localparam logic [6:0] MULT_ONE = 7'h01;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [3:0] DIV_MAX = 4'h9;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // External startup count
  localparam int EXT_STARTUP_CYCLES = 4096;
endpackage

// ---- tb/clock_gen_sva.sv ----
// Port checker for the clock generation control registers
`timescale 1ns/1ps
`default_nettype none
module clock_gen_sva
  import clock_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Requests and modes
  input wire logic [2:0] addr,
  input wire logic wr,
  input wire logic ext_clock_option,
  input wire logic stop_osc_option,
  input wire logic stop_mode,
  // Outputs
  input wire logic monitor_irq,
  input wire logic internal_osc_enable,
  input wire logic external_osc_enable,
  input wire logic osc_select_external,
  input wire logic clocks_running,
  input wire logic [6:0] effective_multiplier,
  input wire logic [3:0] effective_divider,
  input wire logic [6:0] clock_multiplier,
  input wire logic [7:0] clock_trim
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  property p_rst_val;
    $past(rst) |-> internal_osc_enable && !osc_select_external
      && clock_multiplier == MULT_RESET && clock_trim == TRIM_RESET;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
  property p_sel_ext;
    osc_select_external && clocks_running |-> external_osc_enable;
  endproperty
  a_sel_ext: assert property (p_sel_ext) else $error("select without ext");
  property p_int_off;
    clocks_running && !internal_osc_enable |-> osc_select_external;
  endproperty
  a_int_off: assert property (p_int_off) else $error("internal off, not selected ext");
  property p_irq_on;
    monitor_irq |-> internal_osc_enable && external_osc_enable;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq without both clocks");
  // Only checked once the stored value settled, so output latency does not matter
  property p_mult_map;
    $stable(clock_multiplier) |-> effective_multiplier ==
      (clock_multiplier == MULT_ZERO ? MULT_ONE : clock_multiplier);
  endproperty
  a_mult_map: assert property (p_mult_map) else $error("multiplier map wrong");
  property p_mult_wr;
    !$past(rst) && !$stable(clock_multiplier) |-> $past(ce && wr && addr == ADDR_MULT);
  endproperty
  a_mult_wr: assert property (p_mult_wr) else $error("multiplier moved unwritten");
  property p_div_max;
    effective_divider <= DIV_MAX;
  endproperty
  a_div_max: assert property (p_div_max) else $error("divider above nine");
  property p_halt;
    (stop_mode && !stop_osc_option) [*3] |-> !clocks_running;
  endproperty
  a_halt: assert property (p_halt) else $error("clocks run in stop");
  property p_ext_opt;
    (!ext_clock_option) [*3] |-> !external_osc_enable;
  endproperty
  a_ext_opt: assert property (p_ext_opt) else $error("ext on without option");
  c_irq: cover property (monitor_irq);
  c_sel: cover property (osc_select_external);
  c_halt: cover property (!clocks_running);
endmodule
bind clock_gen_control_regs clock_gen_sva u_clock_gen_sva (
  .clk, .rst, .ce, .addr, .wr, .ext_clock_option, .stop_osc_option, .stop_mode,
  .monitor_irq, .internal_osc_enable, .external_osc_enable, .osc_select_external,
  .clocks_running, .effective_multiplier, .effective_divider, .clock_multiplier,
  .clock_trim
);
`default_nettype wire

// ---- tb/test_clock_gen_control_regs.sv ----
// Self-checking bench for the clock generation control registers
`timescale 1ns/1ps
`default_nettype none
module test_clock_gen_control_regs
  import clock_gen_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic ext_clock_option = 1'b0, stop_osc_option = 1'b0, stop_mode = 1'b0;
  logic internal_lock = 1'b0, internal_inactive = 1'b0, external_inactive = 1'b0;
  logic external_clock_edge = 1'b0;
  logic [3:0] filter_divider = 4'hC;
  logic [7:0] filter_stage = 8'hA5;
  logic [7:0] rdata, clock_trim, stage_field;
  logic monitor_irq, internal_osc_enable, external_osc_enable, osc_select_external;
  logic clocks_running;
  logic [6:0] effective_multiplier, clock_multiplier;
  logic [3:0] effective_divider, divider_field;
  int bad_count = 0;
  int n_compared = 0;
  always #10 clk = ~clk;
  // Short startup count keeps the run brief
  clock_gen_control_regs #(.EXT_COUNT(8)) u_clock_gen_control_regs (
    .clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .ext_clock_option,
    .stop_osc_option, .stop_mode, .internal_lock, .internal_inactive,
    .external_inactive, .external_clock_edge, .filter_divider, .filter_stage,
    .monitor_irq, .internal_osc_enable, .external_osc_enable, .osc_select_external,
    .clocks_running, .effective_multiplier, .effective_divider, .clock_multiplier,
    .clock_trim, .divider_field, .stage_field
  );
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Idle edge after each strobe so no strobe is assigned twice in one step
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(nm, e, rdata & m);
    @(posedge clk);
  endtask
  task automatic edges(input int n);
    repeat (n) begin
      external_clock_edge <= 1'b1;
      @(posedge clk);
      external_clock_edge <= 1'b0;
      @(posedge clk);
    end
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("ctrl", ADDR_CONTROL, 8'h08, 8'hFF);
    chk("mult", ADDR_MULT, 8'h15, 8'hFF);
    chk("trim", ADDR_TRIM, 8'h80, 8'hFF);
    chk("unmapped", 3'h7, 8'h00, 8'hFF);
    wr_reg(ADDR_MULT, 8'h00);
    cmp("eff_mult", 8'h01, {1'b0, effective_multiplier});
    wr_reg(ADDR_MULT, 8'h05);
    cmp("mult_reg", 8'h05, {1'b0, clock_multiplier});
    wr_reg(ADDR_TRIM, 8'h33);
    chk("trim", ADDR_TRIM, 8'h33, 8'hFF);
    cmp("trim_reg", 8'h33, clock_trim);
    chk("trim_3v", ADDR_TRIM_3V, 8'h80, 8'hFF);
    wr_reg(ADDR_TRIM, 8'h80);
    wr_reg(ADDR_STAGE, 8'h55);
    chk("stage", ADDR_STAGE, 8'hA5, 8'hFF);
    cmp("stage_reg", 8'hA5, stage_field);
    wr_reg(ADDR_DIVIDER, 8'h02);
    chk("div", ADDR_DIVIDER, 8'h0C, 8'h0F);
    cmp("eff_div", 8'h09, {4'h0, effective_divider});
    cmp("div_reg", 8'h0C, {4'h0, divider_field});
    internal_lock <= 1'b1;
    wr_reg(ADDR_CONTROL, 8'h0A);
    cmp("ext_on", 8'h00, {7'h00, external_osc_enable});
    cmp("int_en", 8'h01, {7'h00, internal_osc_enable});
    ext_clock_option <= 1'b1;
    wr_reg(ADDR_CONTROL, 8'h0A);
    wr_reg(ADDR_CONTROL, 8'h3A);
    edges(7);
    chk("ctrl", ADDR_CONTROL, 8'h0E, 8'hFF);
    edges(1);
    chk("ctrl", ADDR_CONTROL, 8'h0F, 8'hFF);
    wr_reg(ADDR_CONTROL, 8'h1B);
    cmp("sel", 8'h01, {7'h00, osc_select_external});
    wr_reg(ADDR_CONTROL, 8'h3B);
    wr_reg(ADDR_CONTROL, 8'hBB);
    chk("ctrl", ADDR_CONTROL, 8'hBF, 8'hFF);
    cmp("irq", 8'h00, {7'h00, monitor_irq});
    wr_reg(ADDR_MULT, 8'h22);
    chk("mult", ADDR_MULT, 8'h05, 8'hFF);
    external_inactive <= 1'b1;
    @(posedge clk);
    external_inactive <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("irq", 8'h01, {7'h00, monitor_irq});
    cmp("sel", 8'h00, {7'h00, osc_select_external});
    chk("ctrl", ADDR_CONTROL, 8'hEA, 8'hFB);
    wr_reg(ADDR_CONTROL, 8'hAA);
    chk("ctrl", ADDR_CONTROL, 8'hAA, 8'hFA);
    cmp("irq", 8'h00, {7'h00, monitor_irq});
    wr_reg(ADDR_CONTROL, 8'h8A);
    chk("ctrl", ADDR_CONTROL, 8'h0A, 8'hFA);
    internal_lock <= 1'b0;
    wr_reg(ADDR_MULT, 8'h05);
    chk("ctrl", ADDR_CONTROL, 8'h00, 8'h04);
    internal_lock <= 1'b1;
    stop_osc_option <= 1'b1;
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    cmp("run", 8'h01, {7'h00, clocks_running});
    stop_osc_option <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("run", 8'h00, {7'h00, clocks_running});
    cmp("int_en", 8'h00, {7'h00, internal_osc_enable});
    chk("ctrl", ADDR_CONTROL, 8'h0A, 8'hFF);
    close_out;
  end
endmodule
`default_nettype wire
